/* src/dgr_pkg.sv */
// Shared constants and types of the de-gamma and resize pixel path
package dgr_pkg;

  // Array geometry
  localparam int unsigned DGR_ARRAY_N  = 1152;
  localparam int unsigned DGR_COORD_W  = 11;
  localparam logic [10:0] DGR_LAST_IDX = 11'h47f;  // 1151
  localparam logic [10:0] DGR_HALF_IDX = 11'h23f;  // 575, last half col
  localparam logic [10:0] DGR_ROWS_FULL = 11'h480; // 1152 input rows
  localparam logic [10:0] DGR_ROWS_HALF = 11'h240; // 576 input rows
  localparam logic [10:0] DGR_ROWS_QTR  = 11'h120; // 288 input rows

  // Pixel and curve widths
  localparam int unsigned DGR_PIX_W   = 8;
  localparam int unsigned DGR_EXT_W   = 10;   // 8 integer + 2 fraction
  localparam int unsigned DGR_LUT_N   = 256;
  localparam logic [7:0]  DGR_LUT_TOP = 8'hff;

  // Ordered dither mask, 4x4, thresholds 0..15
  localparam int unsigned DGR_MASK_W = 4;
  localparam logic [3:0] DGR_MASK [16] = '{
    4'h0, 4'h8, 4'h2, 4'ha,
    4'hc, 4'h4, 4'he, 4'h6,
    4'h3, 4'hb, 4'h1, 4'h9,
    4'hf, 4'h7, 4'hd, 4'h5
  };

  // Resize modes
  typedef enum logic [1:0] {
    DGR_MODE_NATIVE = 2'h0,  // 1152 x 1152
    DGR_MODE_V2     = 2'h1,  // 1152 x 576
    DGR_MODE_HV2R   = 2'h2   // 576 x 288
  } dgr_mode_t;

  // Frame sequencer states
  typedef enum logic [2:0] {
    DGR_ST_IDLE = 3'b001,
    DGR_ST_LOAD = 3'b010,
    DGR_ST_EMIT = 3'b100
  } dgr_state_t;

endpackage : dgr_pkg

/* src/dgr_mem.sv */
// Small memory with one write port and several registered read ports
`timescale 1ns/1ps
module dgr_mem #(
  parameter int unsigned W   = 8,
  parameter int unsigned D   = 256,
  parameter int unsigned NRD = 2,
  parameter int unsigned AW  = $clog2(D)
) (
  // Clock
  input  wire logic                 clk_i,
  // Write port
  input  wire logic                 we_i,
  input  wire logic [AW-1:0]        waddr_i,
  input  wire logic [W-1:0]         wdata_i,
  // Read ports, packed one after another
  input  wire logic                 re_i,
  input  wire logic [NRD*AW-1:0]    raddr_i,
  output logic      [NRD*W-1:0]     rdata_o
);

  logic [W-1:0] mem [D];

  if (D > (1 << AW) || NRD == 0) begin : g_chk
    $error("dgr_mem: depth or port count not servable");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered reads, held while re_i is low
  for (genvar g = 0; g < NRD; g++) begin : g_rd
    always_ff @(posedge clk_i) begin
      if (re_i) begin
        rdata_o[g*W +: W] <= mem[raddr_i[g*AW +: AW]];
      end
    end
  end

endmodule : dgr_mem

/* src/dgr_pixel_path.sv */
// Pixel path: line store, resize, flip, de-gamma and dither quantizer
// Operation
// - Every pixel passes the programmable de-gamma table
// - Pixels widened beyond 8 bits before de-gamma
// - De-gamma feeds dither quantizer producing sequence bits
// - Output addresses 1152 by 1152 diamond array
// - Row and column origin is bottom-left
// - Horizontal and vertical flips selectable independently
// - Polyphase two-phase interpolation is the resizer
// - Row replication only beyond scaler limit
// - Every mode fills the whole array
// - 1152x576: 1x horizontal, 2x vertical, no replication
// - 576x288: 2x both ways, rows replicated 2x
// - Native 1152x1152 bypasses scaling and replication
// - Round up when fraction exceeds mask threshold
// - Zero and full scale pass unchanged
`timescale 1ns/1ps
module dgr_pixel_path
  import dgr_pkg::*;
#(
  parameter int unsigned DW  = 12,  // de-gamma output width
  parameter int unsigned SEQ = 8    // sequence bit depth
) (
  // Clock and reset
  input  wire logic                   CORE_CLK_I,
  input  wire logic                   RSTN_I,
  // De-gamma table load
  input  wire logic                   LUT_WE_I,
  input  wire logic [7:0]             LUT_ADDR_I,
  input  wire logic [DW-1:0]          LUT_DATA_I,
  // Frame settings
  input  wire logic                   FLIP_H_I,
  input  wire logic                   FLIP_V_I,
  input  wire logic [1:0]             MODE_I,
  // Video in
  input  wire logic [DGR_PIX_W-1:0]   PIX_I,
  input  wire logic                   PIX_VALID_I,
  input  wire logic                   PIX_SOF_I,
  output logic                        PIX_READY_O,
  // Array out
  output logic [SEQ-1:0]              OUT_BITS_O,
  output logic [DGR_COORD_W-1:0]      OUT_ROW_O,
  output logic [DGR_COORD_W-1:0]      OUT_COL_O,
  output logic                        OUT_VALID_O,
  input  wire logic                   OUT_READY_I,
  // Status
  output logic                        FRAME_BUSY_O
);

  localparam int unsigned RW = DW - SEQ;   // remainder bits

  if (SEQ < 1 || DW < SEQ + DGR_MASK_W || DW < DGR_EXT_W) begin : g_chk
    $error("dgr_pixel_path: DW must exceed SEQ by at least 4");
  end

  dgr_state_t       state_r;
  logic             cfg_hs_r, cfg_vs_r, cfg_rep_r, flip_h_r, flip_v_r;
  logic [10:0]      in_col_r, in_row_r, out_col_r, out_row_r;
  logic             wr_bank_r, a_bank_r, edge_r;
  logic [1:0]       sub_r;
  logic             v1_r, v2_r;
  logic             hf1_r, vf1_r;
  logic [1:0]       f2_r;
  logic [10:0]      row1_r, col1_r, row2_r, col2_r;
  logic             en, acc, busy, mode_hs, mode_vs, mode_rep;
  logic [10:0]      col_last, rows_total, c0, c1;
  logic [1:0]       sub_last;
  logic             vph, b_bank;
  logic [47:0]      lb_raddr;
  logic [31:0]      lb_rdata;
  logic [15:0]      lut_raddr;
  logic [2*DW-1:0]  lut_rdata;
  logic [8:0]       ha, hb;
  logic [9:0]       xv;
  logic [7:0]       idx_n;
  logic [DW-1:0]    l0, l1, dg;
  logic [DW+1:0]    prod;
  logic [SEQ-1:0]   q;
  logic [RW-1:0]    rem, thr;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode; unknown codes fall back to native
  always_comb begin
    mode_hs  = (MODE_I == DGR_MODE_HV2R);
    mode_vs  = (MODE_I == DGR_MODE_V2) || (MODE_I == DGR_MODE_HV2R);
    mode_rep = (MODE_I == DGR_MODE_HV2R);
  end

  // Geometry of the latched mode
  always_comb begin
    col_last   = cfg_hs_r ? DGR_HALF_IDX : DGR_LAST_IDX;
    rows_total = cfg_rep_r ? DGR_ROWS_QTR
               : (cfg_vs_r ? DGR_ROWS_HALF : DGR_ROWS_FULL);
    sub_last   = {cfg_vs_r & cfg_rep_r, cfg_vs_r | cfg_rep_r};
    vph        = cfg_vs_r & (cfg_rep_r ? sub_r[1] : sub_r[0]);
    b_bank     = edge_r ? a_bank_r : ~a_bank_r;   // Last row pairs itself
  end

  // Handshakes
  assign en           = ~OUT_VALID_O | OUT_READY_I;
  assign busy         = (state_r != DGR_ST_IDLE) | v1_r | v2_r | OUT_VALID_O;
  assign FRAME_BUSY_O = busy;
  assign PIX_READY_O  = (state_r != DGR_ST_EMIT);
  assign acc          = PIX_VALID_I & PIX_READY_O
                      & ((state_r == DGR_ST_LOAD) | PIX_SOF_I);

  ////////////////////////////////////////////////////////////////////////////
  // Settings latched at start of frame only
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      cfg_hs_r  <= 1'b0;
      cfg_vs_r  <= 1'b0;
      cfg_rep_r <= 1'b0;
      flip_h_r  <= 1'b0;
      flip_v_r  <= 1'b0;
    end else if (acc && state_r == DGR_ST_IDLE) begin
      cfg_hs_r  <= mode_hs;
      cfg_vs_r  <= mode_vs;
      cfg_rep_r <= mode_rep;
      flip_h_r  <= FLIP_H_I;
      flip_v_r  <= FLIP_V_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: load input rows, then emit output rows
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      state_r   <= DGR_ST_IDLE;
      in_col_r  <= 11'h000;
      in_row_r  <= 11'h000;
      wr_bank_r <= 1'b0;
      a_bank_r  <= 1'b0;
      edge_r    <= 1'b0;
      out_col_r <= 11'h000;
      out_row_r <= 11'h000;
      sub_r     <= 2'h0;
    end else begin
      unique case (state_r)
        DGR_ST_IDLE: begin
          if (acc) begin
            in_col_r <= 11'h001;
            state_r  <= DGR_ST_LOAD;
          end
        end
        DGR_ST_LOAD: begin
          if (acc) begin
            if (in_col_r == col_last) begin
              in_col_r  <= 11'h000;
              in_row_r  <= in_row_r + 11'h001;
              wr_bank_r <= ~wr_bank_r;
              a_bank_r  <= wr_bank_r ^ cfg_vs_r;  // Older row when scaling
              if (!(cfg_vs_r && in_row_r == 11'h000)) begin
                state_r <= DGR_ST_EMIT;
              end
            end else begin
              in_col_r <= in_col_r + 11'h001;
            end
          end
        end
        DGR_ST_EMIT: begin
          if (en) begin
            if (out_col_r == DGR_LAST_IDX) begin
              out_col_r <= 11'h000;
              out_row_r <= out_row_r + 11'h001;
              if (sub_r == sub_last) begin
                sub_r <= 2'h0;
                if (out_row_r == DGR_LAST_IDX) begin
                  state_r   <= DGR_ST_IDLE;
                  out_row_r <= 11'h000;
                  in_row_r  <= 11'h000;
                  wr_bank_r <= 1'b0;
                  edge_r    <= 1'b0;
                end else if (in_row_r == rows_total) begin
                  edge_r   <= 1'b1;
                  a_bank_r <= ~a_bank_r;
                end else begin
                  state_r <= DGR_ST_LOAD;
                end
              end else begin
                sub_r <= sub_r + 2'h1;
              end
            end else begin
              out_col_r <= out_col_r + 11'h001;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line store, two banks, four neighbour taps
  always_comb begin
    c0 = cfg_hs_r ? {1'b0, out_col_r[10:1]} : out_col_r;
    c1 = (c0 == col_last) ? c0 : c0 + 11'h001;    // Edge column repeats
    lb_raddr = {b_bank, c1, b_bank, c0, a_bank_r, c1, a_bank_r, c0};
  end

  dgr_mem #(.W(DGR_PIX_W), .D(4096), .NRD(4), .AW(12)) u_line (
    .clk_i   (CORE_CLK_I),
    .we_i    (acc),
    .waddr_i ({wr_bank_r, in_col_r}),
    .wdata_i (PIX_I),
    .re_i    (en),
    .raddr_i (lb_raddr),
    .rdata_o (lb_rdata)
  );

  // Stage 1 tags: phase and bottom-left array coordinates
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      v1_r   <= 1'b0;
      hf1_r  <= 1'b0;
      vf1_r  <= 1'b0;
      row1_r <= 11'h000;
      col1_r <= 11'h000;
    end else if (en) begin
      v1_r   <= (state_r == DGR_ST_EMIT);
      hf1_r  <= cfg_hs_r & out_col_r[0];
      vf1_r  <= vph;
      row1_r <= flip_v_r ? out_row_r
              : DGR_LAST_IDX - out_row_r;
      col1_r <= flip_h_r ? DGR_LAST_IDX - out_col_r
              : out_col_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-phase polyphase interpolation into 8.2 precision
  always_comb begin
    ha = hf1_r ? {1'b0, lb_rdata[7:0]} + {1'b0, lb_rdata[15:8]}
               : {lb_rdata[7:0], 1'b0};
    hb = hf1_r ? {1'b0, lb_rdata[23:16]} + {1'b0, lb_rdata[31:24]}
               : {lb_rdata[23:16], 1'b0};
    xv = vf1_r ? {1'b0, ha} + {1'b0, hb} : {ha, 1'b0};
    idx_n = (xv[9:2] == DGR_LUT_TOP) ? xv[9:2] : xv[9:2] + 8'h01;
    lut_raddr = {idx_n, xv[9:2]};
  end

  // Writes only between frames keep the curve fixed in a frame
  dgr_mem #(.W(DW), .D(DGR_LUT_N), .NRD(2), .AW(8)) u_curve (
    .clk_i   (CORE_CLK_I),
    .we_i    (LUT_WE_I & ~busy),
    .waddr_i (LUT_ADDR_I),
    .wdata_i (LUT_DATA_I),
    .re_i    (en),
    .raddr_i (lut_raddr),
    .rdata_o (lut_rdata)
  );

  // Stage 2 tags
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      v2_r   <= 1'b0;
      f2_r   <= 2'h0;
      row2_r <= 11'h000;
      col2_r <= 11'h000;
    end else if (en) begin
      v2_r   <= v1_r;
      f2_r   <= xv[1:0];
      row2_r <= row1_r;
      col2_r <= col1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // De-gamma with fractional interpolation, then dithered quantizer
  always_comb begin
    l0   = lut_rdata[DW-1:0];
    l1   = lut_rdata[2*DW-1:DW];
    prod = (l1 - l0) * f2_r;                       // Curve is monotonic
    dg   = l0 + prod[DW+1:2];
    q    = dg[DW-1 -: SEQ];
    rem  = dg[RW-1:0];
    thr  = RW'(DGR_MASK[{row2_r[1:0], col2_r[1:0]}]) << (RW - DGR_MASK_W);
  end

  // Output register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      OUT_VALID_O <= 1'b0;
      OUT_BITS_O  <= '0;
      OUT_ROW_O   <= 11'h000;
      OUT_COL_O   <= 11'h000;
    end else if (en) begin
      OUT_VALID_O <= v2_r;
      OUT_BITS_O  <= ((rem > thr) && (q != {SEQ{1'b1}}))
                   ? q + 1'b1 : q;
      OUT_ROW_O   <= row2_r;
      OUT_COL_O   <= col2_r;
    end
  end

endmodule : dgr_pixel_path

/* test/dgr_pixel_path_monitor.sv */
// Checker of the pixel path output stream
`timescale 1ns/1ps
module dgr_pixel_path_monitor
  import dgr_pkg::*;
#(
  parameter int unsigned DW  = 12,
  parameter int unsigned SEQ = 8
) (
  // Clock and reset
  input wire logic            CORE_CLK_I,
  input wire logic            RSTN_I,
  // Settings and video in
  input wire logic            FLIP_H_I,
  input wire logic            FLIP_V_I,
  input wire logic            PIX_VALID_I,
  input wire logic            PIX_SOF_I,
  input wire logic            PIX_READY_O,
  // Array out
  input wire logic [SEQ-1:0]  OUT_BITS_O,
  input wire logic [10:0]     OUT_ROW_O,
  input wire logic [10:0]     OUT_COL_O,
  input wire logic            OUT_VALID_O,
  input wire logic            OUT_READY_I,
  input wire logic            FRAME_BUSY_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [10:0] prow_r;
  logic [10:0] pcol_r;
  logic        have_r;
  // Remember the coordinates of the last word taken
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) have_r <= 1'b0;
    else if (OUT_VALID_O && OUT_READY_I) have_r <= 1'b1;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (OUT_VALID_O && OUT_READY_I) begin
      prow_r <= OUT_ROW_O;
      pcol_r <= OUT_COL_O;
    end
  end
  sequence word_taken; OUT_VALID_O && OUT_READY_I; endsequence
  sequence sof_taken; PIX_SOF_I && PIX_VALID_I && PIX_READY_O; endsequence
  sequence same_row; have_r && OUT_ROW_O == prow_r; endsequence
  sequence new_row; have_r && OUT_ROW_O != prow_r; endsequence
  //////////////////////////////////////////////////////////////////////////
  word_hold_a: assert property (OUT_VALID_O && !OUT_READY_I
    |=> OUT_VALID_O && $stable(OUT_BITS_O) && $stable(OUT_ROW_O)
    && $stable(OUT_COL_O))
    else $error("output word changed before taken");
  coord_range_a: assert property (OUT_VALID_O
    |-> OUT_ROW_O <= DGR_LAST_IDX && OUT_COL_O <= DGR_LAST_IDX)
    else $error("coordinate beyond array");
  first_word_a: assert property (word_taken ##0 !have_r
    |-> OUT_COL_O == (FLIP_H_I ? DGR_LAST_IDX : 11'h0)
    && OUT_ROW_O == (FLIP_V_I ? 11'h0 : DGR_LAST_IDX))
    else $error("first word not at frame corner");
  col_step_a: assert property (word_taken ##0 same_row
    |-> OUT_COL_O == (FLIP_H_I ? pcol_r - 11'h1 : pcol_r + 11'h1))
    else $error("column order wrong");
  row_step_a: assert property (word_taken ##0 new_row
    |-> pcol_r == (FLIP_H_I ? 11'h0 : DGR_LAST_IDX)
    && OUT_COL_O == (FLIP_H_I ? DGR_LAST_IDX : 11'h0)
    && OUT_ROW_O == (FLIP_V_I ? prow_r + 11'h1 : prow_r - 11'h1))
    else $error("row order wrong");
  busy_out_a: assert property (!FRAME_BUSY_O |=> !OUT_VALID_O)
    else $error("output launched while idle");
  sof_busy_a: assert property (sof_taken |=> FRAME_BUSY_O)
    else $error("frame start without busy");
  idle_ready_a: assert property (!FRAME_BUSY_O |-> PIX_READY_O)
    else $error("idle but not ready");
  emit_start_a: assert property ($fell(PIX_READY_O)
    |-> ##3 OUT_VALID_O) else $error("no output three cycles into emit");
endmodule : dgr_pixel_path_monitor
bind dgr_pixel_path dgr_pixel_path_monitor #(.DW(DW), .SEQ(SEQ)) i_mon (
  .CORE_CLK_I, .RSTN_I, .FLIP_H_I, .FLIP_V_I, .PIX_VALID_I, .PIX_SOF_I,
  .PIX_READY_O, .OUT_BITS_O, .OUT_ROW_O, .OUT_COL_O, .OUT_VALID_O,
  .OUT_READY_I, .FRAME_BUSY_O);

/* test/dgr_video_src.sv */
// Video source model feeding 8-bit frames to the pixel path
`timescale 1ns/1ps
module dgr_video_src (
  // Clock
  input wire logic   clk_i,
  // Video out
  output logic [7:0] pix_o,
  output logic       valid_o,
  output logic       sof_o,
  input wire logic   ready_i
);
  logic [8:0] q[$];  // Start flag and pixel
  bit         slow = 0;
  bit         taken = 0;
  initial begin
    pix_o = 8'h0;
    valid_o = 1'b0;
    sof_o = 1'b0;
  end
  // Note whether the word shown was taken at this edge
  always @(posedge clk_i) taken = valid_o && ready_i;
  // Hold a word until taken, then show the next, with gaps when slow
  always @(negedge clk_i) begin
    if (taken && q.size() > 0) void'(q.pop_front());
    if (valid_o && !taken && q.size() > 0) begin
    end else if (q.size() > 0 && (!slow || $urandom % 8 != 0)) begin
      valid_o <= 1'b1;
      pix_o <= q[0][7:0];
      sof_o <= q[0][8];
    end else begin
      valid_o <= 1'b0;
      sof_o <= 1'b0;
      pix_o <= ~pix_o;
    end
  end
  task automatic flush;
    q.delete();
  endtask : flush
endmodule : dgr_video_src

/* test/dgr_pixel_path_test.sv */
// Self-checking bench of the de-gamma and resize pixel path
`timescale 1ns/1ps
module dgr_pixel_path_test;
  import dgr_pkg::*;
  localparam int DW = 12;
  localparam int SEQ = 8;
  logic clk, rstn, lut_we, flip_h, flip_v, out_ready, busy;
  logic [7:0] lut_addr, pix;
  logic [DW-1:0] lut_data;
  logic [1:0] mode;
  logic pix_valid, pix_sof, pix_ready, out_valid;
  logic [SEQ-1:0] out_bits;
  logic [10:0] out_row, out_col;
  int lut[256], px[2][1152], eb[$], er[$], ec[$];
  int miscompares = 0, cmp_count = 0, cycles = 0;
  dgr_pixel_path #(.DW(DW), .SEQ(SEQ)) i_dgr_pixel_path (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .LUT_WE_I(lut_we),
    .LUT_ADDR_I(lut_addr), .LUT_DATA_I(lut_data), .FLIP_H_I(flip_h),
    .FLIP_V_I(flip_v), .MODE_I(mode), .PIX_I(pix), .PIX_VALID_I(pix_valid),
    .PIX_SOF_I(pix_sof), .PIX_READY_O(pix_ready), .OUT_BITS_O(out_bits),
    .OUT_ROW_O(out_row), .OUT_COL_O(out_col), .OUT_VALID_O(out_valid),
    .OUT_READY_I(out_ready), .FRAME_BUSY_O(busy));
  dgr_video_src i_dgr_video_src (.clk_i(clk), .pix_o(pix),
    .valid_o(pix_valid), .sof_o(pix_sof), .ready_i(pix_ready));
  //////////////////////////////////////////////////////////////////////////
  // Clock, timeout and sink stalls
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      give_verdict();
    end
  end
  always @(negedge clk) out_ready <= ($urandom % 4) != 0;
  task automatic give_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // Curve, interpolation and ordered-mask rounding of one extended value
  function automatic int qz(int v, int r, int c);
    int i, cv, q;
    i = v >> 2;
    cv = lut[i] + (i < 255 ? (lut[i+1] - lut[i]) * (v % 4) / 4 : 0);
    q = cv >> (DW - SEQ);
    if (cv % (1 << (DW - SEQ)) > (int'(DGR_MASK[(r % 4) * 4 + c % 4]) <<
        (DW - SEQ - 4)) && q < (1 << SEQ) - 1) q++;
    return q;
  endfunction : qz
  // Compare one taken word with the head of the expected queues
  task automatic cmp(input logic [SEQ-1:0] b, input logic [10:0] r, c);
    cmp_count++;
    if (b !== SEQ'(eb[0]) || r !== 11'(er[0]) || c !== 11'(ec[0])) begin
      miscompares++;
      $display("MISMATCH %0t r%0d c%0d bits %0h exp r%0d c%0d bits %0h",
        $time, r, c, b, er[0], ec[0], eb[0]);
    end
    void'(eb.pop_front());
    void'(er.pop_front());
    void'(ec.pop_front());
  endtask : cmp
  always @(posedge clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1 && eb.size() > 0)
      cmp(out_bits, out_row, out_col);
  end
  // One frame start: load input rows, predict output rows, then abort
  task automatic run_frame(input int m, fh, fv);
    int w, nin, nout, v, c, c1, h0, h1, row, col;
    w = (m == 2) ? 576 : 1152;
    nin = (m == 1 || m == 2) ? 2 : 1;
    nout = (m == 2) ? 4 : nin;
    @(negedge clk);
    mode <= 2'(m);
    flip_h <= 1'(fh);
    flip_v <= 1'(fv);
    i_dgr_video_src.slow = 1'(fh);
    for (int r = 0; r < nin; r++) for (int k = 0; k < w; k++) begin
      px[r][k] = $urandom % 256;
      i_dgr_video_src.q.push_back({1'(r == 0 && k == 0), 8'(px[r][k])});
    end
    // Half-width rows: even columns copy, odd ones average, edge repeats
    for (int ro = 0; ro < nout; ro++) for (int k = 0; k < 1152; k++) begin
      c = (m == 2) ? k / 2 : k;
      c1 = (m == 2 && k % 2 == 1 && c < 575) ? c + 1 : c;
      h0 = px[0][c] + px[0][c1];
      h1 = px[1][c] + px[1][c1];
      v = ((m == 1 && ro == 1) || (m == 2 && ro > 1)) ? h0 + h1
        : h0 * 2;
      row = fv ? ro : 1151 - ro;
      col = fh ? 1151 - k : k;
      eb.push_back(qz(v, row, col));
      er.push_back(row);
      ec.push_back(col);
    end
    // Curve write while busy must be dropped
    wait (busy === 1'b1);
    @(negedge clk);
    lut_we <= 1'b1;
    lut_addr <= 8'h80;
    lut_data <= '0;
    @(negedge clk);
    lut_we <= 1'b0;
    while (eb.size() > 0) @(posedge clk);
    @(negedge clk);
    rstn <= 1'b0;
    i_dgr_video_src.flush();
    repeat (2) @(negedge clk);
    rstn <= 1'b1;
  endtask : run_frame
  // Main sequence
  initial begin
    rstn = 1'b0;
    lut_we = 1'b0;
    lut_addr = 8'h0;
    lut_data = '0;
    flip_h = 1'b0;
    flip_v = 1'b0;
    mode = 2'h0;
    out_ready = 1'b0;
    void'($urandom(32'hc428b6b3));
    repeat (16) @(negedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(negedge clk);
      lut[i] = i * ((1 << DW) - 1) / 255;
      lut_we <= 1'b1;
      lut_addr <= 8'(i);
      lut_data <= DW'(lut[i]);
    end
    @(negedge clk);
    lut_we <= 1'b0;
    for (int f = 0; f < 8; f++)
      run_frame(f % 4, f / 4, ((f / 2) % 2) ^ (f / 4));
    give_verdict();
  end
endmodule : dgr_pixel_path_test
